/* hdl/bst_map.vh */
`ifndef BST_MAP_VH
`define BST_MAP_VH
// Instruction register width and codes
`define BST_IR_W        4
`define BST_IR_EXTEST   4'h0
`define BST_IR_IDCODE   4'h1
`define BST_IR_SAMPLE   4'h2
`define BST_IR_CHIPRST  4'hc
`define BST_IR_BYPASS   4'hf
`define BST_IR_CAPTURE  4'h1
// Identification word field positions
`define BST_ID_VER_MSB  31
`define BST_ID_VER_LSB  28
`define BST_ID_PART_MSB 27
`define BST_ID_PART_LSB 12
`define BST_ID_MFR_MSB  11
`define BST_ID_MFR_LSB  1
`define BST_ID_W        32
// Register offsets and fields
`define BST_OFF_CSR     4'h0
`define BST_OFF_STAT    4'h4
`define BST_CSR_DIS     7
`define BST_CSR_TRF     4
`define BST_CSR_RST     1'b0
`define BST_ST_EN       0
`define BST_ST_IR_LSB   1
`define BST_ST_CRST     5
`define BST_ST_EXT      6
// Bus responses
`define BST_RESP_OKAY   2'b00
`define BST_RESP_SLVERR 2'b10
// Reset time-out defaults in clk_sys cycles
`define BST_TMO_SHORT   16
`define BST_TMO_LONG    64
`endif

/* hdl/bst_sync.v */
`timescale 1ns/1ps
// Two-stage synchroniser for levels from outside the clock domain
module bst_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         rst,
  // Data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;

  // First stage feeds only the second
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

/* hdl/bst_tap.v */
// Contract
// RQ1: Instruction register holds four bits, sixteen possible codes.
// RQ2: All shift registers shift least significant bit in and out first.
// RQ3: Identification instruction is active after reset and test-logic-reset.
// RQ4: Code 0x1 selects 32-bit identification register; capture loads, shift shifts.
// RQ5: Top four bits carry the silicon revision number.
// RQ6: Bits 27 to 12 carry the 16-bit part number.
// RQ7: Bits 11 to 1 carry manufacturer code, bit 0 is one.
// RQ8: Code 0x0 selects chain; latches drive pins once instruction is loaded.
// RQ9: External test captures pins, shifts chain, update applies to outputs.
// RQ10: Code 0x2 selects chain and captures pins without disturbing the system.
// RQ11: Instruction_a update loads latches only, pins stay with the system.
// RQ12: Controller preloads safe values before first external test.
// RQ13: Code 0xC selects one-bit reset register; port controller not reset.
// RQ14: A one in the reset register holds the chip in reset.
// RQ15: Reset register output has no update stage, reset acts at once.
// RQ16: After release the chip stays in reset for an option-dependent time-out.
// RQ17: In reset every pin output goes to high impedance immediately.
// RQ18: Code 0xF selects the single-stage bypass register.
// RQ19: Bypass stage loads zero in capture before shifting.
// RQ20: Port works only with enable fuse set and disable bit clear.
// RQ21: Scan works with any test clock rate relative to the chip; code samples tck on clk_sys, so tck must run well below clk_sys.
// RQ22: Test reset sets a flag cleared by brown-out or writing zero.
// RQ23: Sixteen-state controller follows TMS on rising edges, TDO on falling.
// RQ24: Unassigned codes select the bypass register.
`timescale 1ns/1ps
`include "bst_map.vh"
module bst_tap #(
  parameter       N_PINS       = 8,
  parameter [3:0] ID_VERSION   = 4'h0,
  parameter [15:0] ID_PART     = 16'h5a3c, // Arbitrary value
  parameter [10:0] ID_MFR      = 11'h2a5,  // Arbitrary value
  parameter       TMO_SHORT    = `BST_TMO_SHORT,
  parameter       TMO_LONG     = `BST_TMO_LONG,
  parameter       TMO_W        = 16
) (
  // System clock and reset
  input  wire              clk_sys,
  input  wire              rst,
  // Test port pins
  input  wire              tck,
  input  wire              tms,
  input  wire              tdi,
  output reg               tdo,
  output reg               tdo_oe_n,
  // Straps and reset sources
  input  wire              tap_enable_fuse,
  input  wire              clk_opt_long,
  input  wire              ext_rst_n,
  input  wire              bor,
  output reg               chip_rst_n,
  // Port pins and core side
  input  wire [N_PINS-1:0] pin_in,
  output reg  [N_PINS-1:0] pin_out,
  output reg  [N_PINS-1:0] pin_oe_n,
  input  wire [N_PINS-1:0] sys_out,
  input  wire [N_PINS-1:0] sys_oe,
  // AXI4-Lite write
  input  wire [3:0]        s_awaddr,
  input  wire              s_awvalid,
  output reg               s_awready,
  input  wire [31:0]       s_wdata,
  input  wire [3:0]        s_wstrb,
  input  wire              s_wvalid,
  output reg               s_wready,
  output reg  [1:0]        s_bresp,
  output reg               s_bvalid,
  input  wire              s_bready,
  // AXI4-Lite read
  input  wire [3:0]        s_araddr,
  input  wire              s_arvalid,
  output reg               s_arready,
  output reg  [31:0]       s_rdata,
  output reg  [1:0]        s_rresp,
  output reg               s_rvalid,
  input  wire              s_rready
);
  localparam L = 2 * N_PINS;
  // Controller states, one-hot
  localparam [15:0] S_TLR  = 16'h0001;
  localparam [15:0] S_RTI  = 16'h0002;
  localparam [15:0] S_SDS  = 16'h0004;
  localparam [15:0] S_CDR  = 16'h0008;
  localparam [15:0] S_SDR  = 16'h0010;
  localparam [15:0] S_E1D  = 16'h0020;
  localparam [15:0] S_PDR  = 16'h0040;
  localparam [15:0] S_E2D  = 16'h0080;
  localparam [15:0] S_UDR  = 16'h0100;
  localparam [15:0] S_SIS  = 16'h0200;
  localparam [15:0] S_CIR  = 16'h0400;
  localparam [15:0] S_SIR  = 16'h0800;
  localparam [15:0] S_E1I  = 16'h1000;
  localparam [15:0] S_PIR  = 16'h2000;
  localparam [15:0] S_E2I  = 16'h4000;
  localparam [15:0] S_UIR  = 16'h8000;
  // Data register selections
  localparam [1:0] SEL_BYP = 2'd0;
  localparam [1:0] SEL_ID  = 2'd1;
  localparam [1:0] SEL_BS  = 2'd2;
  localparam [1:0] SEL_RST = 2'd3;
  localparam [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

  // Instruction to data register decode
  function [1:0] sel_of;
    input [`BST_IR_W-1:0] code;
    begin
      case (code)
        `BST_IR_IDCODE:  sel_of = SEL_ID;
        `BST_IR_EXTEST:  sel_of = SEL_BS;
        `BST_IR_SAMPLE:  sel_of = SEL_BS;
        `BST_IR_CHIPRST: sel_of = SEL_RST;
        default:         sel_of = SEL_BYP; // [RQ18] [RQ24]
      endcase
    end
  endfunction

  // Next controller state
  function [15:0] nxt;
    input [15:0] s;
    input        m;
    begin
      case (s)
        S_TLR:   nxt = m ? S_TLR : S_RTI;
        S_RTI:   nxt = m ? S_SDS : S_RTI;
        S_SDS:   nxt = m ? S_SIS : S_CDR;
        S_CDR:   nxt = m ? S_E1D : S_SDR;
        S_SDR:   nxt = m ? S_E1D : S_SDR;
        S_E1D:   nxt = m ? S_UDR : S_PDR;
        S_PDR:   nxt = m ? S_E2D : S_PDR;
        S_E2D:   nxt = m ? S_UDR : S_SDR;
        S_UDR:   nxt = m ? S_SDS : S_RTI;
        S_SIS:   nxt = m ? S_TLR : S_CIR;
        S_CIR:   nxt = m ? S_E1I : S_SIR;
        S_SIR:   nxt = m ? S_E1I : S_SIR;
        S_E1I:   nxt = m ? S_UIR : S_PIR;
        S_PIR:   nxt = m ? S_E2I : S_PIR;
        S_E2I:   nxt = m ? S_UIR : S_SIR;
        S_UIR:   nxt = m ? S_SDS : S_RTI;
        default: nxt = S_TLR;
      endcase
    end
  endfunction

  wire [N_PINS-1:0] pin_s;
  wire              tck_s;
  wire              tms_s;
  wire              tdi_s;
  wire              fuse_s;
  wire              ext_rst_n_s;
  reg               tck_prev_q;
  reg  [15:0]       st_q;
  reg  [3:0]        ir_q;
  reg  [3:0]        ir_sr_q;
  reg  [31:0]       id_sr_q;
  reg               byp_q;
  reg               rst_bit_q;
  reg  [L-1:0]      bs_sr_q;
  reg  [L-1:0]      bs_upd_q;
  reg  [TMO_W-1:0]  tmo_q;
  reg               dis_q;
  reg               trf_q;
  reg               aw_have_q;
  reg               w_have_q;
  reg  [3:0]        awaddr_q;
  reg  [31:0]       wdata_q;
  reg  [3:0]        wstrb_q;
  wire              tck_rise;
  wire              tck_fall;
  wire              tap_en;
  wire [1:0]        sel;
  wire              in_reset;
  wire              extest;
  wire              wr_go;
  wire              csr_wr;
  wire [TMO_W-1:0]  tmo_load;

  // Port pins, test port, fuse and external reset pass two flip-flops; bor and clk_opt_long do not
  bst_sync #(
    .W (N_PINS + 5)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({pin_in, tck, tms, tdi, tap_enable_fuse, ext_rst_n}),
    .q       ({pin_s, tck_s, tms_s, tdi_s, fuse_s, ext_rst_n_s})
  );

  // Test clock edges found by the system clock
  assign tck_rise = tck_s & ~tck_prev_q;                        // [RQ21]
  assign tck_fall = ~tck_s & tck_prev_q;
  assign tap_en   = fuse_s & ~dis_q;                            // [RQ20]
  assign sel      = sel_of(ir_q);
  assign extest   = (ir_q == `BST_IR_EXTEST);
  assign in_reset = rst_bit_q | ~ext_rst_n_s | (tmo_q != {TMO_W{1'b0}});
  assign tmo_load = clk_opt_long ? TMO_LONG[TMO_W-1:0] : TMO_SHORT[TMO_W-1:0];

  // Controller, instruction and data shift registers
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      tck_prev_q <= 1'b0;
      st_q       <= S_TLR;
      ir_q       <= `BST_IR_IDCODE;
      ir_sr_q    <= 4'h0;
      id_sr_q    <= 32'h0;
      byp_q      <= 1'b0;
      rst_bit_q  <= 1'b0;
      bs_sr_q    <= {L{1'b0}};
      bs_upd_q   <= {L{1'b0}};
    end
    else
    begin
      tck_prev_q <= tck_s;
      if (!tap_en)
      begin
        st_q      <= S_TLR;
        ir_q      <= `BST_IR_IDCODE;
        rst_bit_q <= 1'b0;
      end
      else if (tck_rise)
      begin
        st_q <= nxt(st_q, tms_s);                               // [RQ23]
        case (st_q)
          S_TLR:
          begin
            ir_q      <= `BST_IR_IDCODE;                         // [RQ3]
            rst_bit_q <= 1'b0;
          end
          S_CIR: ir_sr_q <= `BST_IR_CAPTURE;
          S_SIR: ir_sr_q <= {tdi_s, ir_sr_q[3:1]};              // [RQ1] [RQ2]
          S_UIR: ir_q    <= ir_sr_q;                             // [RQ8]
          S_CDR:
          begin
            case (sel)
              SEL_ID:  id_sr_q <= ID_WORD;                       // [RQ4] [RQ5] [RQ6] [RQ7]
              SEL_BS:  bs_sr_q <= {~pin_oe_n, pin_s};            // [RQ9] [RQ10]
              SEL_BYP: byp_q   <= 1'b0;                          // [RQ19]
              default: byp_q   <= byp_q;
            endcase
          end
          S_SDR:
          begin
            case (sel)
              SEL_ID:  id_sr_q   <= {tdi_s, id_sr_q[31:1]};      // [RQ2] [RQ4]
              SEL_BS:  bs_sr_q   <= {tdi_s, bs_sr_q[L-1:1]};     // [RQ2] [RQ9]
              SEL_RST: rst_bit_q <= tdi_s;                       // [RQ13]
              default: byp_q     <= tdi_s;                       // [RQ18]
            endcase
          end
          S_UDR:
          begin
            if (sel == SEL_BS)
              bs_upd_q <= bs_sr_q;                               // [RQ9] [RQ11]
          end
          default: st_q <= nxt(st_q, tms_s);
        endcase
      end
    end
  end

  // Test data out changes on falling test clock
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end
    else if (!tap_en)
      tdo_oe_n <= 1'b1;
    else if (tck_fall)
    begin
      tdo_oe_n <= ~((st_q == S_SIR) | (st_q == S_SDR));          // [RQ23]
      if (st_q == S_SIR)
        tdo <= ir_sr_q[0];                                      // [RQ2]
      else
      begin
        case (sel)
          SEL_ID:  tdo <= id_sr_q[0];
          SEL_BS:  tdo <= bs_sr_q[0];
          SEL_RST: tdo <= rst_bit_q;
          default: tdo <= byp_q;
        endcase
      end
    end
  end

  // Chip reset, time-out and pin drivers
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      tmo_q      <= {TMO_W{1'b0}};
      chip_rst_n <= 1'b0;
      pin_out    <= {N_PINS{1'b0}};
      pin_oe_n   <= {N_PINS{1'b1}};
    end
    else
    begin
      if (rst_bit_q | ~ext_rst_n_s)
        tmo_q <= tmo_load;                                      // [RQ16]
      else if (tmo_q != {TMO_W{1'b0}})
        tmo_q <= tmo_q - {{(TMO_W-1){1'b0}}, 1'b1};
      chip_rst_n <= ~in_reset;                                  // [RQ14] [RQ15]
      if (in_reset)
      begin
        pin_out  <= {N_PINS{1'b0}};
        pin_oe_n <= {N_PINS{1'b1}};                              // [RQ17]
      end
      else if (extest)
      begin
        pin_out  <= bs_upd_q[N_PINS-1:0];                        // [RQ8]
        pin_oe_n <= ~bs_upd_q[L-1:N_PINS];
      end
      else
      begin
        pin_out  <= sys_out;                                    // [RQ10] [RQ11]
        pin_oe_n <= ~sys_oe;
      end
    end
  end

  // Bus write acceptance and register update
  assign wr_go  = aw_have_q & w_have_q & ~s_bvalid;
  assign csr_wr = wr_go & (awaddr_q == `BST_OFF_CSR) & wstrb_q[0];

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_bvalid  <= 1'b0;
      s_bresp   <= `BST_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 4'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      dis_q     <= `BST_CSR_RST;
      trf_q     <= `BST_CSR_RST;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        awaddr_q  <= s_awaddr;
        aw_have_q <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        wdata_q  <= s_wdata;
        wstrb_q  <= s_wstrb;
        w_have_q <= 1'b1;
        s_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= (awaddr_q == `BST_OFF_CSR) ? `BST_RESP_OKAY : `BST_RESP_SLVERR;
      end
      if (s_bvalid && s_bready)
      begin
        s_bvalid  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
      if (csr_wr)
        dis_q <= wdata_q[`BST_CSR_DIS];                         // [RQ20]
      // Brown-out clears, test reset sets, software may clear
      if (bor)
        trf_q <= 1'b0;                                          // [RQ22]
      else if (rst_bit_q)
        trf_q <= 1'b1;                                          // [RQ22]
      else if (csr_wr && !wdata_q[`BST_CSR_TRF])
        trf_q <= 1'b0;
    end
  end

  // Bus read path
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= `BST_RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rdata   <= 32'h0;
      s_rresp   <= `BST_RESP_OKAY;
      case (s_araddr)
        `BST_OFF_CSR:
        begin
          s_rdata[`BST_CSR_DIS] <= dis_q;
          s_rdata[`BST_CSR_TRF] <= trf_q;
        end
        `BST_OFF_STAT:
        begin
          s_rdata[`BST_ST_EN]                      <= tap_en;
          s_rdata[`BST_ST_IR_LSB+3:`BST_ST_IR_LSB] <= ir_q;
          s_rdata[`BST_ST_CRST]                    <= ~chip_rst_n;
          s_rdata[`BST_ST_EXT]                     <= extest;
        end
        default: s_rresp <= `BST_RESP_SLVERR;
      endcase
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end
endmodule

/* testbench/bst_chk.sv */
`timescale 1ns/1ps
`include "bst_map.vh"
module bst_chk #(
  parameter N_PINS    = 8,
  parameter TMO_SHORT = 16,
  parameter TMO_LONG  = 64
) (
  // Clock and reset
  input wire              clk_sys,
  input wire              rst,
  // Test port, straps and pins
  input wire              tck,
  input wire              tdo,
  input wire              tdo_oe_n,
  input wire              tap_enable_fuse,
  input wire              clk_opt_long,
  input wire              ext_rst_n,
  input wire              chip_rst_n,
  input wire [N_PINS-1:0] pin_oe_n,
  // Register bus
  input wire              s_awvalid,
  input wire              s_awready,
  input wire              s_wvalid,
  input wire              s_wready,
  input wire              s_bvalid,
  input wire              s_bready,
  input wire [1:0]        s_bresp,
  input wire [3:0]        s_araddr,
  input wire              s_arvalid,
  input wire              s_arready,
  input wire              s_rvalid,
  input wire [1:0]        s_rresp
);
  reg [15:0] low_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Cycles spent in chip reset
  always @(posedge clk_sys)
    low_q <= (rst || chip_rst_n) ? 16'h0 : low_q + 16'h1;

  a_fuse_off_quiet: assert property (!tap_enable_fuse [*6] |-> tdo_oe_n)
    else $error("test data out enabled with fuse off");
  a_ext_rst_hold: assert property (!ext_rst_n [*4] |-> !chip_rst_n)
    else $error("chip reset missing under external reset");
  a_rst_pins_hiz: assert property (!chip_rst_n && !$past(chip_rst_n) |-> &pin_oe_n)
    else $error("pin driven while chip in reset");
  a_timeout_len: assert property ($rose(chip_rst_n) |-> low_q >= (clk_opt_long ? TMO_LONG : TMO_SHORT))
    else $error("reset time-out too short");
  a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck, 2))
    else $error("test data out changed outside low test clock");
  a_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid && !s_arready)
    else $error("read response late");
  a_read_unmapped: assert property (s_arvalid && s_arready && s_araddr != `BST_OFF_CSR
    && s_araddr != `BST_OFF_STAT |=> s_rresp == `BST_RESP_SLVERR)
    else $error("unmapped read not refused");

  // Main scenarios
  c_rst_release: cover property ($rose(chip_rst_n));
  c_shift_on: cover property (!tdo_oe_n);
  c_wr_refused: cover property (s_bvalid && s_bready && s_bresp == `BST_RESP_SLVERR);
endmodule

bind bst_tap bst_chk #(.N_PINS(N_PINS), .TMO_SHORT(TMO_SHORT), .TMO_LONG(TMO_LONG)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .tck(tck), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tap_enable_fuse(tap_enable_fuse),
  .clk_opt_long(clk_opt_long), .ext_rst_n(ext_rst_n), .chip_rst_n(chip_rst_n), .pin_oe_n(pin_oe_n),
  .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
  .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp), .s_araddr(s_araddr),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rresp(s_rresp));

/* testbench/bst_ctl_model.sv */
`timescale 1ns/1ps
module bst_ctl_model (
  // Test port
  output reg  tck,
  output reg  tms,
  output reg  tdi,
  input  wire tdo,
  input  wire tdo_oe_n
);
  // Test clock stands low between frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One 80 ns period, data out taken before the rise
  task automatic step(input logic m, input logic d, output logic o);
    begin
      tms = m;
      tdi = d;
      #40;
      o = tdo_oe_n ? ~tdo : tdo; // Released line reads inverted
      tck = 1'b1;
      #40;
      tck = 1'b0;
    end
  endtask

  // Move state; stale data in is never repeated
  task automatic nav(input logic m);
    logic o;
    begin
      step(m, ~tdi, o);
    end
  endtask

  // Five ones reach Test-Logic-Reset, then idle
  task automatic tap_reset();
    begin
      #3;
      repeat (5) nav(1'b1);
      nav(1'b0);
    end
  endtask

  // Scan n bits from idle back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    int i;
    begin
      #3;
      dout = 32'h0;
      nav(1'b1);
      if (ir)
        nav(1'b1);
      nav(1'b0);
      nav(1'b0);
      for (i = 0; i < n; i++)
        step(i == n - 1, din[i], dout[i]);
      nav(1'b1);
      nav(1'b0);
    end
  endtask
endmodule

/* testbench/bst_tap_tb_top.sv */
`timescale 1ns/1ps
`include "bst_map.vh"
module bst_tap_tb_top;
  localparam [3:0]  VER  = 4'h3;
  localparam [15:0] PART = 16'hc1d2; // Arbitrary value
  localparam [10:0] MFR  = 11'h155;  // Arbitrary value
  localparam        TS   = 20;
  localparam        TL   = 60;
  localparam [1:0]  OK   = `BST_RESP_OKAY;
  localparam [1:0]  SE   = `BST_RESP_SLVERR;
  reg          clk_sys = 1'b0;
  reg          rst     = 1'b1;
  reg          fuse    = 1'b1;
  reg          xrst_n  = 1'b1;
  reg          bor     = 1'b0;
  reg          opt     = 1'b1;
  reg  [7:0]   pin_in  = 8'h3c;
  reg  [7:0]   sys_out = 8'h5a;
  reg  [7:0]   sys_oe  = 8'hff;
  reg  [3:0]   awaddr  = 4'h0;
  reg  [3:0]   araddr  = 4'h0;
  reg  [31:0]  wdata   = 32'h0;
  reg  [3:0]   wstrb   = 4'h0;
  reg          awvalid = 1'b0;
  reg          wvalid  = 1'b0;
  reg          bready  = 1'b0;
  reg          arvalid = 1'b0;
  reg          rready  = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire         tck, tms, tdi, tdo, tdo_oe_n, chip_rst_n;
  wire [7:0]   pin_out, pin_oe_n;
  logic [31:0] q;
  logic [3:0]  codes [6] = '{4'h1, 4'h3, 4'h5, 4'h9, 4'he, 4'hf};
  int          n;
  int          error_cnt = 0;
  int          compares  = 0;

  // System clock
  always #5 clk_sys = ~clk_sys;

  // Far-side test controller and design
  bst_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
  bst_tap #(.N_PINS(8), .ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR), .TMO_SHORT(TS), .TMO_LONG(TL)) DUT (
    .clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .tap_enable_fuse(fuse), .clk_opt_long(opt), .ext_rst_n(xrst_n), .bor(bor), .chip_rst_n(chip_rst_n),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .sys_out(sys_out), .sys_oe(sys_oe),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      compares++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Bus write, response code compared
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er = OK);
    begin
      @(posedge clk_sys);
      awaddr  <= a;
      wdata   <= v;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
        @(posedge clk_sys);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(bresp, er);
    end
  endtask

  // Bus read, masked data and response compared
  task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er = OK);
    begin
      @(posedge clk_sys);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
        @(posedge clk_sys);
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk(rdata & m, e);
      chk(rresp, er);
    end
  endtask

  // Scan from a clock edge and compare what comes out
  task automatic sc(input logic ir, input int nb, input logic [31:0] din, input logic [31:0] e);
    begin
      @(posedge clk_sys);
      ctl.scan(ir, nb, din, q);
      chk(q, e);
    end
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    begin
      if (error_cnt == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // Watchdog
  initial
  begin
    #400000;
    error_cnt++;
    $display("CHECK FAILED %0t watchdog", $time);
    print_verdict();
  end

  // Test sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    ctl.tap_reset();
    rc(4'h4, 32'h1f, 32'h3);
    sc(1'b0, 32, 32'h0, {VER, PART, MFR, 1'b1});
    foreach (codes[k])
    begin
      sc(1'b1, 4, codes[k], 32'h1);
      rc(4'h4, 32'h1e, {codes[k], 1'b0});
      if (codes[k] != 4'h1)
        sc(1'b0, 4, 32'hb, 32'h6);
    end
    // Preload safe values, then drive the pins
    sc(1'b1, 4, 32'h2, 32'h1);
    sc(1'b0, 16, 32'h0fa5, {sys_oe, pin_in});
    chk({pin_oe_n, pin_out}, {~sys_oe, sys_out});
    sc(1'b1, 4, 32'h0, 32'h1);
    chk({pin_oe_n, pin_out}, 16'hf0a5);
    sc(1'b0, 16, 32'hff96, 32'h0f3c);
    chk({pin_oe_n, pin_out}, 16'h0096);
    rc(4'h4, 32'h7f, 32'h41);
    // Chip reset through the one-bit register
    sc(1'b1, 4, 32'hc, 32'h1);
    sc(1'b0, 1, 32'h1, 32'h0);
    chk({chip_rst_n, pin_oe_n}, 9'h0ff);
    rc(4'h4, 32'h3e, 32'h38);
    wr(4'h0, 32'h10);
    rc(4'h0, 32'h10, 32'h10);
    bor <= 1'b1;
    rc(4'h0, 32'h10, 32'h0);
    bor <= 1'b0;
    sc(1'b0, 1, 32'h0, 32'h1);
    for (n = 0; chip_rst_n !== 1'b1; n++)
      @(posedge clk_sys);
    chk(n > TS && n <= TL, 1'b1);
    wr(4'h0, 32'h0);
    rc(4'h0, 32'h10, 32'h0);
    // External reset pin, short time-out option
    xrst_n <= 1'b0;
    opt    <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({chip_rst_n, pin_oe_n}, 9'h0ff);
    xrst_n <= 1'b1;
    for (n = 0; chip_rst_n !== 1'b1; n++)
      @(posedge clk_sys);
    chk(n >= TS && n <= TS + 8, 1'b1);
    // Unmapped access, disable bit and fuse
    wr(4'h8, 32'h80, SE);
    rc(4'hc, 32'hffffffff, 32'h0, SE);
    rc(4'h4, 32'h1, 32'h1);
    wr(4'h0, 32'h80);
    ctl.scan(1'b1, 4, 32'hf, q);
    rc(4'h4, 32'h1f, 32'h2);
    wr(4'h0, 32'h0);
    fuse <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rc(4'h4, 32'h1, 32'h0);
    fuse <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rc(4'h4, 32'h1, 32'h1);
    print_verdict();
  end
endmodule
